// >>> common/hcfg_pkg.sv
// Package with register indices, field positions and reset values
package hcfg_pkg;
  localparam logic [7:0] IDX_READONLY_A = 8'h0a;
  localparam logic [7:0] IDX_READONLY_B = 8'h0b;
  localparam logic [7:0] IDX_NATIVE_WINDOW_BASE = 8'h13;
  localparam logic [7:0] IDX_BIOS_DECODE_CONTROL = 8'h30;
  localparam logic [7:0] IDX_BIOS_BASE_LOW = 8'h31;
  localparam logic [7:0] IDX_BIOS_BASE_MID = 8'h32;
  localparam logic [7:0] IDX_BIOS_BASE_HIGH = 8'h33;
  localparam logic [7:0] IDX_BUS_STRAP_STATUS = 8'h40;

  localparam int ROM_ENABLE_BIT = 0;
  localparam int BASE_LOW_BIT = 7;
  localparam int STATUS_BUS_LSB = 6;
  localparam int STATUS_STRAP_LSB = 3;
  localparam int STATUS_SPROM_BIT = 0;

  localparam logic [7:0] RST_NATIVE_WINDOW_BASE = 8'h00;
  localparam logic RST_ROM_ENABLE_VL = 1'b1;
  localparam logic RST_ROM_ENABLE_PCI = 1'b0;
  localparam logic RST_BASE_LOW = 1'b0;
  localparam logic [7:0] RST_BASE_MID = 8'h0c;
  localparam logic [7:0] RST_BASE_HIGH = 8'h00;

  localparam logic [1:0] BUS_VL = 2'b10;
  localparam logic [1:0] BUS_PCI = 2'b01;

  localparam int ROM_BASE_W = 17;
  localparam int ROM_OFS_W = 15;
  localparam int HOST_ADDR_W = 32;

  // One host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } hcfg_req_s;

  // Result of a ROM decode
  typedef struct packed {
    logic hit;
    logic [ROM_OFS_W-1:0] offset;
  } hcfg_rom_s;
endpackage

// >>> core/hcfg_regs.sv
// Host configuration register bank with BIOS ROM decode
`timescale 1ns/1ps
`default_nettype none
module hcfg_regs #(
  parameter logic [7:0] READONLY_A_VALUE = 8'h00,
  parameter logic [7:0] READONLY_B_VALUE = 8'h00
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Bus type strap: 1 local bus, 0 PCI
  input wire logic bus_is_vl,
  input wire logic [2:0] config_port_base_select,
  input wire logic serial_prom_data_in,
  // I/O cycle register port (local bus)
  input wire hcfg_pkg::hcfg_req_s io_req,
  // Configuration cycle register port (PCI)
  input wire hcfg_pkg::hcfg_req_s cfg_req,
  output logic [7:0] rdata,
  output logic rvalid,
  // ROM decode
  input wire logic mem_enable,
  input wire logic [hcfg_pkg::HOST_ADDR_W-1:0] host_addr,
  input wire logic host_addr_valid,
  output logic rom_hit,
  output logic [hcfg_pkg::ROM_OFS_W-1:0] rom_offset,
  // Register values for other decoders
  output logic [7:0] native_window_base,
  output logic rom_enable
);
  initial begin
    if (hcfg_pkg::ROM_BASE_W + hcfg_pkg::ROM_OFS_W != hcfg_pkg::HOST_ADDR_W)
      $error("ROM base and offset widths must cover the host address");
  end

  logic [7:0] nwb_ff, nxt_nwb;
  logic ren_ff, nxt_ren;
  logic base0_ff, nxt_base0;
  logic [7:0] bmid_ff, nxt_bmid;
  logic [7:0] bhigh_ff, nxt_bhigh;
  logic [7:0] rdata_ff, nxt_rdata;
  logic rvalid_ff, nxt_rvalid;
  logic hit_ff, nxt_hit;
  logic [hcfg_pkg::ROM_OFS_W-1:0] ofs_ff, nxt_ofs;
  logic [1:0] bus_ff, nxt_bus;
  logic rst_seen_ff;
  hcfg_pkg::hcfg_req_s req;
  hcfg_pkg::hcfg_rom_s rom;

  function automatic logic [7:0] status_byte(input logic [1:0] bus,
                                             input logic [2:0] strap,
                                             input logic sprom);
    logic [7:0] s;
    s = 8'h00;
    s[hcfg_pkg::STATUS_BUS_LSB +: 2] = bus;
    s[hcfg_pkg::STATUS_STRAP_LSB +: 3] = strap;
    s[hcfg_pkg::STATUS_SPROM_BIT] = sprom;
    return s;
  endfunction

  // Port chosen by bus type
  always_comb begin
    req = bus_is_vl ? io_req : cfg_req;
  end

  // Register next values
  always_comb begin
    nxt_nwb = nwb_ff;
    nxt_ren = ren_ff;
    nxt_base0 = base0_ff;
    nxt_bmid = bmid_ff;
    nxt_bhigh = bhigh_ff;
    nxt_bus = bus_is_vl ? hcfg_pkg::BUS_VL : hcfg_pkg::BUS_PCI;
    nxt_rvalid = req.rd;
    nxt_rdata = rdata_ff;
    if (!rst_seen_ff) begin
      // Bus-dependent reset value taken on the first edge with ce high after release
      nxt_ren = bus_is_vl ? hcfg_pkg::RST_ROM_ENABLE_VL
                          : hcfg_pkg::RST_ROM_ENABLE_PCI;
    end else if (req.wr) begin
      case (req.index)
        hcfg_pkg::IDX_NATIVE_WINDOW_BASE: nxt_nwb = req.wdata;
        hcfg_pkg::IDX_BIOS_DECODE_CONTROL:
          nxt_ren = req.wdata[hcfg_pkg::ROM_ENABLE_BIT];
        hcfg_pkg::IDX_BIOS_BASE_LOW:
          nxt_base0 = req.wdata[hcfg_pkg::BASE_LOW_BIT];
        hcfg_pkg::IDX_BIOS_BASE_MID: nxt_bmid = req.wdata;
        hcfg_pkg::IDX_BIOS_BASE_HIGH: nxt_bhigh = req.wdata;
        // Index 10, 11 and 64 writes dropped
        default: nxt_nwb = nwb_ff;
      endcase
    end
    if (req.rd) begin
      case (req.index)
        hcfg_pkg::IDX_READONLY_A: nxt_rdata = READONLY_A_VALUE;
        hcfg_pkg::IDX_READONLY_B: nxt_rdata = READONLY_B_VALUE;
        hcfg_pkg::IDX_NATIVE_WINDOW_BASE: nxt_rdata = nwb_ff;
        hcfg_pkg::IDX_BIOS_DECODE_CONTROL:
          nxt_rdata = {7'h00, ren_ff};
        hcfg_pkg::IDX_BIOS_BASE_LOW:
          nxt_rdata = {base0_ff, 7'h00};
        hcfg_pkg::IDX_BIOS_BASE_MID: nxt_rdata = bmid_ff;
        hcfg_pkg::IDX_BIOS_BASE_HIGH: nxt_rdata = bhigh_ff;
        hcfg_pkg::IDX_BUS_STRAP_STATUS:
          nxt_rdata = status_byte(bus_ff, config_port_base_select,
                                  serial_prom_data_in);
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // ROM decode
  always_comb begin
    rom.offset = host_addr[hcfg_pkg::ROM_OFS_W-1:0];
    rom.hit = host_addr_valid && mem_enable && ren_ff &&
              (host_addr[hcfg_pkg::HOST_ADDR_W-1:hcfg_pkg::ROM_OFS_W] ==
               {bhigh_ff, bmid_ff, base0_ff});
    nxt_hit = rom.hit;
    nxt_ofs = rom.offset;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      nwb_ff <= hcfg_pkg::RST_NATIVE_WINDOW_BASE;
      ren_ff <= hcfg_pkg::RST_ROM_ENABLE_PCI;
      base0_ff <= hcfg_pkg::RST_BASE_LOW;
      bmid_ff <= hcfg_pkg::RST_BASE_MID;
      bhigh_ff <= hcfg_pkg::RST_BASE_HIGH;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      hit_ff <= 1'b0;
      ofs_ff <= '0;
      bus_ff <= 2'b00;
      rst_seen_ff <= 1'b0;
    end else if (ce) begin
      nwb_ff <= nxt_nwb;
      ren_ff <= nxt_ren;
      base0_ff <= nxt_base0;
      bmid_ff <= nxt_bmid;
      bhigh_ff <= nxt_bhigh;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      hit_ff <= nxt_hit;
      ofs_ff <= nxt_ofs;
      bus_ff <= nxt_bus;
      rst_seen_ff <= 1'b1;
    end
  end

  always_comb begin
    rdata = rdata_ff;
    rvalid = rvalid_ff;
    rom_hit = hit_ff;
    rom_offset = ofs_ff;
    native_window_base = nwb_ff;
    rom_enable = ren_ff;
  end
endmodule
`default_nettype wire

// >>> verification/hcfg_host.sv
// Host bus master issuing register cycles
`timescale 1ns/1ps
`default_nettype none
module hcfg_host (
  input wire logic clk,
  input wire logic rvalid,
  input wire logic [7:0] rdata,
  output var hcfg_pkg::hcfg_req_s io_req = '0,
  output var hcfg_pkg::hcfg_req_s cfg_req = '0
);
  // One cycle; released strobes go low, index and data show inverted values
  task automatic acc(input logic vl, w, input logic [7:0] i, d,
    output logic [7:0] r);
    hcfg_pkg::hcfg_req_s q;
    q = '{w, !w, i, d};
    r = 8'hxx;
    @(posedge clk);
    #1;
    if (vl) io_req = q;
    else cfg_req = q;
    @(posedge clk);
    #1;
    q = '{1'b0, 1'b0, ~i, ~d};
    io_req = q;
    cfg_req = q;
    if (!w && rvalid === 1'b1) r = rdata;
  endtask
endmodule
`default_nettype wire

// >>> verification/hcfg_props.sv
// Checker of host configuration register behaviour
`timescale 1ns/1ps
`default_nettype none
module hcfg_props (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic bus_is_vl,
  input wire hcfg_pkg::hcfg_req_s io_req,
  input wire hcfg_pkg::hcfg_req_s cfg_req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic mem_enable,
  input wire logic [31:0] host_addr,
  input wire logic rom_hit,
  input wire logic [14:0] rom_offset,
  input wire logic [7:0] native_window_base,
  input wire logic rom_enable
);
  hcfg_pkg::hcfg_req_s q;
  assign q = bus_is_vl ? io_req : cfg_req;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_rd(i); ce && q.rd && q.index == i; endsequence
  sequence s_wr(i); ce && q.wr && q.index == i; endsequence
  property p_rv; ce && q.rd |=> rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_wb; s_wr(8'h13) |=>
    native_window_base == $past(q.wdata); endproperty
  a_wb: assert property (p_wb) else $error("bad base");
  property p_en; s_wr(8'h30) |=> rom_enable == $past(q.wdata[0]); endproperty
  a_en: assert property (p_en) else $error("bad enable");
  property p_rs; $rose(resetn) && ce |=> rom_enable == bus_is_vl; endproperty
  a_rs: assert property (p_rs) else $error("bad enable reset");
  property p_st; s_rd(8'h40) |=>
    rdata[7:6] == {bus_is_vl, !bus_is_vl}; endproperty
  a_st: assert property (p_st) else $error("bad bus code");
  property p_lo; s_rd(8'h31) |=> rdata[6:0] == 7'h00; endproperty
  a_lo: assert property (p_lo) else $error("bad low base");
  property p_hit; rom_hit |-> $past(mem_enable && rom_enable); endproperty
  a_hit: assert property (p_hit) else $error("bad hit");
  property p_ofs; ce |=> rom_offset == $past(host_addr[14:0]); endproperty
  a_ofs: assert property (p_ofs) else $error("bad offset");
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Bench for the host configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, bus_is_vl = 1'b1;
  logic serial_prom_data_in = 1'b1, mem_enable = 1'b0, host_addr_valid = 1'b1;
  logic [2:0] config_port_base_select = 3'h5;
  logic [31:0] host_addr = 32'h0;
  logic [7:0] rdata, native_window_base, r;
  logic rvalid, rom_hit, rom_enable;
  logic [14:0] rom_offset;
  hcfg_pkg::hcfg_req_s io_req, cfg_req;
  int miscompares = 0, n_tests = 0;
  always #2 clk = ~clk;
  hcfg_regs #(.READONLY_A_VALUE(8'h5a)) dut_u (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .bus_is_vl(bus_is_vl),
    .config_port_base_select(config_port_base_select),
    .serial_prom_data_in(serial_prom_data_in),
    .io_req(io_req),
    .cfg_req(cfg_req),
    .rdata(rdata),
    .rvalid(rvalid),
    .mem_enable(mem_enable),
    .host_addr(host_addr),
    .host_addr_valid(host_addr_valid),
    .rom_hit(rom_hit),
    .rom_offset(rom_offset),
    .native_window_base(native_window_base),
    .rom_enable(rom_enable)
  );
  hcfg_host host_u (
    .clk(clk),
    .rvalid(rvalid),
    .rdata(rdata),
    .io_req(io_req),
    .cfg_req(cfg_req)
  );
  task automatic cmp(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic rc(input logic [7:0] i, e);
    host_u.acc(bus_is_vl, 1'b0, i, 8'h00, r);
    cmp(r, e);
  endtask
  task automatic wc(input logic [7:0] i, d);
    host_u.acc(bus_is_vl, 1'b1, i, d, r);
  endtask
  task automatic probe(input logic [31:0] x, input logic m, e);
    host_addr = x;
    mem_enable = m;
    @(posedge clk);
    #1 cmp(rom_hit, e);
    cmp(rom_offset, x[14:0]);
  endtask
  task automatic t_rst(input logic bus);
    bus_is_vl = bus;
    resetn = 1'b0;
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    @(posedge clk);
    rc(8'h32, 8'h0c);
    rc(8'h33, 8'h00);
    rc(8'h30, {7'h00, bus});
  endtask
  task automatic t_ro;
    wc(8'h0a, 8'hff);
    wc(8'h0b, 8'hff);
    wc(8'h40, 8'h00);
    rc(8'h0a, 8'h5a);
    rc(8'h0b, 8'h00);
    rc(8'h40, {bus_is_vl, !bus_is_vl, 6'h29});
  endtask
  task automatic t_win;
    wc(8'h13, 8'ha5);
    host_u.acc(!bus_is_vl, 1'b1, 8'h13, 8'h3c, r);
    rc(8'h13, 8'ha5);
    ce = 1'b0;
    wc(8'h13, 8'h3c);
    ce = 1'b1;
    rc(8'h13, 8'ha5);
  endtask
  task automatic t_rom;
    wc(8'h31, 8'hff);
    rc(8'h31, 8'h80);
    wc(8'h33, 8'h81);
    wc(8'h30, 8'h01);
    probe({8'h81, 8'h0c, 1'b1, 15'h1234}, 1'b1, 1'b1);
    probe({8'h81, 8'h0c, 1'b0, 15'h1234}, 1'b1, 1'b0);
    probe({8'h81, 8'h0c, 1'b1, 15'h0000}, 1'b0, 1'b0);
    wc(8'h30, 8'h00);
    probe({8'h81, 8'h0c, 1'b1, 15'h0042}, 1'b1, 1'b0);
  endtask
  task automatic stop_test;
    $display("compares %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    t_rst(1'b1);
    t_ro;
    t_win;
    t_rom;
    t_rst(1'b0);
    t_ro;
    t_win;
    t_rom;
    stop_test;
  end
endmodule
bind hcfg_regs hcfg_props props_u (
  .clk(clk),
  .resetn(resetn),
  .ce(ce),
  .bus_is_vl(bus_is_vl),
  .io_req(io_req),
  .cfg_req(cfg_req),
  .rdata(rdata),
  .rvalid(rvalid),
  .mem_enable(mem_enable),
  .host_addr(host_addr),
  .rom_hit(rom_hit),
  .rom_offset(rom_offset),
  .native_window_base(native_window_base),
  .rom_enable(rom_enable)
);
`default_nettype wire
